/* File: logic/adc_init_pkg.sv */
package adc_init_pkg;
  // Register addresses on the serial configuration port
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_BYPASS = 8'h24;
  localparam logic [7:0] ADDR_OUTPUT_FORMAT = 8'h8f;
  // Field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int BYPASS_BIT = 2;
  localparam int FORMAT_A_BIT = 1;
  // Values loaded from fuses when a reset is released
  localparam logic FUSE_BYPASS = 1'h0;
  localparam logic FUSE_FORMAT_A = 1'h0;
  // Serial frame: read flag, 15 address bits, 8 data bits, MSB first
  localparam int HDR_BITS = 16;
  localparam int FRAME_BITS = 24;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CAL_CYCLES = 200000;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYCLES =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_RESET,
    ST_LOAD,
    ST_CAL,
    ST_READY
  } seq_state_type;
endpackage : adc_init_pkg

/* File: logic/cal_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module cal_timer #(
  parameter int CYCLES = adc_init_pkg::CAL_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count;

  // Counts one full calibration; a new start restarts it from zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        count <= '0;
      end else if (busy) begin
        if (count == LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

  a_cal_bounded: assert property (@(posedge clk_sys) disable iff (!rst_n)
    busy |-> count <= LAST) // [RL6]
    else $error("calibration count overran");
endmodule : cal_timer
`default_nettype wire

/* File: logic/adc_init_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RL1] Format bit 0 twos complement, 1 offset binary
// [RL2] Format applies only with bypass bit set
// [RL3] Host pulses reset pin high at least 1 us
// [RL4] Host sets reference pin and clock before reset
// [RL5] Host waits 100 ns before reset rising edge
// [RL6] Release loads fuse defaults, then 200000-cycle calibration
// [RL7] Host waits calibration before programming any register
// [RL8] Soft reset bit restores defaults, clears itself
// [RL9] Host keeps reset pin low during soft reset
module adc_init_seq #(
  parameter int SAMPLE_W = 14,
  parameter int CAL_CYCLES = adc_init_pkg::CAL_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Device pins
  input wire logic hw_reset,
  input wire logic reference_mode_pin,
  // Serial configuration port
  input wire logic serial_port_select_n,
  input wire logic serial_clk,
  input wire logic serial_din,
  output logic serial_dout,
  output logic serial_dout_oe,
  // Channel A samples
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic [SAMPLE_W-1:0] sample_out,
  // Status
  output logic reference_mode,
  output logic cal_busy
);
  // Pins in order: reset, reference, select, clock, data
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic sclk_d;
  logic hw_reset_s;
  logic sel_n_s;
  logic sclk_rise;
  logic sdi_s;
  adc_init_pkg::seq_state_type state;
  logic cal_start;
  logic cal_done;
  logic bypass_en;
  logic format_sel;
  logic soft_reset_bit;
  logic [4:0] bit_cnt;
  logic [22:0] shift_in;
  logic [7:0] shift_out;
  logic wr_commit;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  // True when the upper address bits are zero and the low byte matches
  function automatic logic addr_hit(input logic [14:0] a,
                                    input logic [7:0] target);
    addr_hit = (a[14:8] == 7'h00) && (a[7:0] == target);
  endfunction : addr_hit

  // Read image of a register; unmapped addresses read zero
  function automatic logic [7:0] reg_image(input logic [14:0] a,
                                           input logic byp,
                                           input logic fmt,
                                           input logic srst);
    logic [7:0] v;
    v = 8'h00;
    if (addr_hit(a, adc_init_pkg::ADDR_SOFT_RESET))
      v[adc_init_pkg::SOFT_RESET_BIT] = srst;
    else if (addr_hit(a, adc_init_pkg::ADDR_BYPASS))
      v[adc_init_pkg::BYPASS_BIT] = byp;
    else if (addr_hit(a, adc_init_pkg::ADDR_OUTPUT_FORMAT))
      v[adc_init_pkg::FORMAT_A_BIT] = fmt;
    reg_image = v;
  endfunction : reg_image

  // Two flops on every pin; only the second stage feeds logic
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_meta <= 5'h04; // Select idles high, so no false select
      pin_sync <= 5'h04;
      sclk_d <= 1'b0;
    end else begin
      pin_meta <= {serial_din, serial_clk, serial_port_select_n,
                   reference_mode_pin, hw_reset};
      pin_sync <= pin_meta;
      sclk_d <= pin_sync[3];
    end
  end

  assign hw_reset_s = pin_sync[0];
  assign sel_n_s = pin_sync[2];
  assign sdi_s = pin_sync[4];
  assign sclk_rise = pin_sync[3] & ~sclk_d & ~sel_n_s;

  // Reset, fuse load, calibration, ready; the pin wins over the soft bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= adc_init_pkg::ST_RESET;
    end else if (hw_reset_s) begin
      state <= adc_init_pkg::ST_RESET; // [RL3] [RL9]
    end else begin
      unique case (state)
        adc_init_pkg::ST_RESET: state <= adc_init_pkg::ST_LOAD; // [RL6]
        adc_init_pkg::ST_LOAD: state <= adc_init_pkg::ST_CAL; // [RL6]
        adc_init_pkg::ST_CAL: begin
          if (cal_done)
            state <= adc_init_pkg::ST_READY;
        end
        adc_init_pkg::ST_READY: begin
          if (soft_reset_bit)
            state <= adc_init_pkg::ST_LOAD; // [RL8]
        end
      endcase
    end
  end

  assign cal_start = (state == adc_init_pkg::ST_LOAD); // [RL6]

  cal_timer #(
    .CYCLES(CAL_CYCLES)
  ) u_cal_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(cal_start),
    .busy(cal_busy),
    .done(cal_done)
  );

  // Reference strap is caught as the reset lets go, not under reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      reference_mode <= 1'b0;
    else if (state == adc_init_pkg::ST_RESET && !hw_reset_s)
      reference_mode <= pin_sync[1]; // [RL4]
  end

  // Serial frame capture; bits past the frame end are ignored
  always_ff @(posedge clk_sys) begin
    if (!rst_n || sel_n_s) begin
      bit_cnt <= 5'h00;
      shift_in <= 23'h000000;
    end else if (sclk_rise && bit_cnt != 5'(adc_init_pkg::FRAME_BITS)) begin
      bit_cnt <= bit_cnt + 5'h01;
      shift_in <= {shift_in[21:0], sdi_s};
    end
  end

  assign wr_commit = sclk_rise && !shift_in[22] &&
    bit_cnt == 5'(adc_init_pkg::FRAME_BITS - 1) &&
    state == adc_init_pkg::ST_READY; // [RL7]
  assign wr_addr = shift_in[14:7];
  assign wr_data = {shift_in[6:0], sdi_s};

  // Read data goes out MSB first after the header
  always_ff @(posedge clk_sys) begin
    if (!rst_n || sel_n_s) begin
      shift_out <= 8'h00;
      serial_dout_oe <= 1'b0;
    end else if (sclk_rise) begin
      if (bit_cnt == 5'(adc_init_pkg::HDR_BITS - 1)) begin
        shift_out <= reg_image({shift_in[13:0], sdi_s}, bypass_en,
                               format_sel, soft_reset_bit);
        serial_dout_oe <= shift_in[14];
      end else begin
        shift_out <= {shift_out[6:0], 1'b0};
        if (bit_cnt == 5'(adc_init_pkg::FRAME_BITS - 1))
          serial_dout_oe <= 1'b0;
      end
    end
  end

  assign serial_dout = shift_out[7];

  // Registers: fuse values during reset and load, writes only when ready;
  // a set soft bit loads defaults and drops after exactly one cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bypass_en <= adc_init_pkg::FUSE_BYPASS;
      format_sel <= adc_init_pkg::FUSE_FORMAT_A;
      soft_reset_bit <= 1'b0;
    end else if (state == adc_init_pkg::ST_RESET ||
                 state == adc_init_pkg::ST_LOAD || soft_reset_bit) begin
      bypass_en <= adc_init_pkg::FUSE_BYPASS; // [RL6] [RL8]
      format_sel <= adc_init_pkg::FUSE_FORMAT_A;
      soft_reset_bit <= 1'b0; // [RL8]
    end else if (wr_commit) begin
      if (addr_hit({shift_in[21:15], wr_addr},
                   adc_init_pkg::ADDR_SOFT_RESET))
        soft_reset_bit <= wr_data[adc_init_pkg::SOFT_RESET_BIT]; // [RL8]
      if (addr_hit({shift_in[21:15], wr_addr}, adc_init_pkg::ADDR_BYPASS))
        bypass_en <= wr_data[adc_init_pkg::BYPASS_BIT];
      if (addr_hit({shift_in[21:15], wr_addr},
                   adc_init_pkg::ADDR_OUTPUT_FORMAT))
        format_sel <= wr_data[adc_init_pkg::FORMAT_A_BIT];
    end
  end

  // Offset binary is two's complement with the sign bit flipped
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      sample_out <= '0;
    else if (bypass_en && format_sel) // [RL2]
      sample_out <= {~sample_in[SAMPLE_W-1], sample_in[SAMPLE_W-2:0]}; // [RL1]
    else
      sample_out <= sample_in; // [RL1]
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_offset_binary: assert property (rst_n && bypass_en && format_sel |=> // [RL1]
    sample_out == {~$past(sample_in[SAMPLE_W-1]),
                   $past(sample_in[SAMPLE_W-2:0])})
    else $error("offset binary output wrong");
  a_format_gated: assert property (rst_n && // [RL2]
    !(bypass_en && format_sel) |=> sample_out == $past(sample_in))
    else $error("format applied without bypass");
  a_pin_reset_holds: assert property (hw_reset_s |=> // [RL3]
    state == adc_init_pkg::ST_RESET)
    else $error("pin reset not held");
  a_load_then_cal: assert property (rst_n && // [RL6]
    state == adc_init_pkg::ST_RESET && !hw_reset_s ##1 !hw_reset_s |=>
    cal_busy)
    else $error("calibration did not start after release");
  a_defaults_loaded: assert property (state == adc_init_pkg::ST_LOAD |=> // [RL6]
    bypass_en == adc_init_pkg::FUSE_BYPASS &&
    format_sel == adc_init_pkg::FUSE_FORMAT_A)
    else $error("fuse defaults not loaded");
  a_cal_no_write: assert property (state == adc_init_pkg::ST_CAL &&
    !hw_reset_s |=> $stable(bypass_en) && $stable(format_sel)) // [RL7]
    else $error("register changed during calibration");
  a_soft_self_clear: assert property (soft_reset_bit |=> // [RL8]
    !soft_reset_bit)
    else $error("soft reset bit did not clear");
  a_soft_defaults: assert property (soft_reset_bit && !hw_reset_s |-> // [RL8]
    ##2 bypass_en == adc_init_pkg::FUSE_BYPASS &&
    format_sel == adc_init_pkg::FUSE_FORMAT_A && cal_busy)
    else $error("soft reset did not restore defaults");

  c_ready: cover property (state == adc_init_pkg::ST_CAL ##1
    state == adc_init_pkg::ST_READY);
  c_soft_reset: cover property (soft_reset_bit);
  c_offset_out: cover property (bypass_en && format_sel);
  c_read_frame: cover property ($rose(serial_dout_oe));
endmodule : adc_init_seq
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int HALF = 5
) (
  // Clock
  input wire logic clk_sys,
  // Device pins
  output logic hw_reset,
  output logic reference_mode_pin,
  // Serial port
  output logic serial_port_select_n,
  output logic serial_clk,
  output logic serial_din,
  input wire logic serial_dout
);
  // Pins idle: reset low, port deselected
  initial begin
    hw_reset = 1'h0;
    reference_mode_pin = 1'h0;
    serial_port_select_n = 1'h1;
    serial_clk = 1'h0;
    serial_din = 1'h0;
  end

  // Strap first while the clock runs, then a pulse of at least 1 us
  task automatic power_up(input logic strap);
    @(posedge clk_sys) reference_mode_pin <= strap;
    repeat (6) @(posedge clk_sys);
    hw_reset <= 1'h1;
    repeat (adc_init_pkg::RESET_MIN_CYCLES + 1) @(posedge clk_sys);
    hw_reset <= 1'h0;
  endtask : power_up

  // One frame, MSB first; hw_reset stays low throughout
  task automatic xfer(input logic rd, input logic [7:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rd, 7'h00, addr, wdata};
    rdata = 8'h00;
    @(posedge clk_sys) serial_port_select_n <= 1'h0;
    for (int i = 23; i >= 0; i--) begin
      serial_din <= frame[i];
      serial_clk <= 1'h0;
      repeat (HALF) @(posedge clk_sys);
      // Read data is settled well before the next rise
      if (i < 8) rdata[i] = serial_dout;
      serial_clk <= 1'h1;
      repeat (HALF) @(posedge clk_sys);
    end
    serial_clk <= 1'h0;
    repeat (HALF) @(posedge clk_sys);
    serial_port_select_n <= 1'h1;
    // Released line must not keep showing the last bit
    serial_din <= ~frame[0];
    repeat (HALF) @(posedge clk_sys);
  endtask : xfer
endmodule : host_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CAL = 400;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [13:0] sample_in = 14'h1a5c;
  wire logic hw_reset, ref_pin, sel_n, sclk, sdin;
  logic [13:0] sample_out;
  logic sdout, sdout_oe, reference_mode, cal_busy;
  logic [7:0] rd;
  int n;
  int n_mismatch = 0;
  int checks_done = 0;

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  host_model i_host (.clk_sys(clk_sys), .hw_reset(hw_reset),
    .reference_mode_pin(ref_pin), .serial_port_select_n(sel_n),
    .serial_clk(sclk), .serial_din(sdin), .serial_dout(sdout));

  adc_init_seq #(.SAMPLE_W(14), .CAL_CYCLES(CAL)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hw_reset(hw_reset),
    .reference_mode_pin(ref_pin), .serial_port_select_n(sel_n),
    .serial_clk(sclk), .serial_din(sdin), .serial_dout(sdout),
    .serial_dout_oe(sdout_oe), .sample_in(sample_in),
    .sample_out(sample_out), .reference_mode(reference_mode),
    .cal_busy(cal_busy));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Waits briefly for calibration to start, then counts its cycles
  task automatic cal_len(output int len);
    len = 0;
    for (int k = 0; k < 20 && cal_busy !== 1'h1; k++) @(posedge clk_sys);
    while (cal_busy === 1'h1 && len < 2 * CAL) begin
      @(posedge clk_sys);
      len++;
    end
  endtask : cal_len

  task automatic test_power_up;
    // The calibration after rst_n must end first, or the measured run
    // below would merge with it
    repeat (4) @(posedge clk_sys);
    while (cal_busy !== 1'h0) @(posedge clk_sys);
    i_host.power_up(1'h1);
    cal_len(n);
    check("cal length", 16'(n), 16'(CAL));
    check("strap", {15'h0, reference_mode}, 16'h1);
    i_host.xfer(1'h1, adc_init_pkg::ADDR_OUTPUT_FORMAT, 8'h00, rd);
    check("format default", {8'h0, rd}, 16'h0);
    check("dout oe idle", {15'h0, sdout_oe}, 16'h0);
    i_host.xfer(1'h1, 8'h10, 8'h00, rd);
    check("unmapped read", {8'h0, rd}, 16'h0);
    $display("test power_up done");
  endtask : test_power_up

  // All four bypass/format combinations; only both set gives offset binary
  task automatic test_format;
    logic [13:0] exp;
    for (int c = 0; c < 4; c++) begin
      i_host.xfer(1'h0, adc_init_pkg::ADDR_BYPASS, {5'h00, c[1], 2'h0}, rd);
      i_host.xfer(1'h0, adc_init_pkg::ADDR_OUTPUT_FORMAT,
                  {6'h00, c[0], 1'h0}, rd);
      i_host.xfer(1'h1, adc_init_pkg::ADDR_OUTPUT_FORMAT, 8'h00, rd);
      check("format readback", {8'h0, rd}, {14'h0, c[0], 1'h0});
      exp = (c == 3) ? (sample_in ^ 14'h2000) : sample_in;
      repeat (2) @(posedge clk_sys);
      check("sample out", {2'h0, sample_out}, {2'h0, exp});
    end
    $display("test format done");
  endtask : test_format

  // Soft reset with the pin low; writes during calibration are dropped
  task automatic test_soft_reset;
    i_host.xfer(1'h0, adc_init_pkg::ADDR_SOFT_RESET, 8'h01, rd);
    check("cal after soft reset", {15'h0, cal_busy}, 16'h1);
    i_host.xfer(1'h0, adc_init_pkg::ADDR_OUTPUT_FORMAT, 8'h02, rd);
    cal_len(n);
    i_host.xfer(1'h1, adc_init_pkg::ADDR_OUTPUT_FORMAT, 8'h00, rd);
    check("format after reset", {8'h0, rd}, 16'h0);
    i_host.xfer(1'h1, adc_init_pkg::ADDR_BYPASS, 8'h00, rd);
    check("bypass after reset", {8'h0, rd}, 16'h0);
    i_host.xfer(1'h1, adc_init_pkg::ADDR_SOFT_RESET, 8'h00, rd);
    check("reset bit cleared", {8'h0, rd}, 16'h0);
    check("sample plain", {2'h0, sample_out}, {2'h0, sample_in});
    $display("test soft_reset done");
  endtask : test_soft_reset

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    test_power_up();
    test_format();
    test_soft_reset();
    wrap_up();
  end

  // Tests need under 8000 cycles; a hang is cut well beyond that
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
